// ---- logic/fts_frame_gen.sv ----
/*
  outbound frame position counter: steps on each bit tick, wraps at the
  end of a frame, and restarts on a frame reference edge.
  assumes tick and restart come from flops on the same clock.
*/
`timescale 1ns/1ps
module fts_frame_gen (
  input wire logic clock_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic hold_i, // keep counter parked at zero
  input wire logic tick_i, // one bit time elapsed
  input wire logic restart_i, // start a new frame now
  output logic frame_start_o, // pulse: first bit of a frame
  output logic [fts_pkg::FTS_POS_W-1:0] pos_o // bit position in frame
);
  import fts_pkg::*;

  typedef struct packed {
    logic [FTS_POS_W-1:0] pos;
    logic start;
  } fts_fg_st_t;

  fts_fg_st_t st_q;
  fts_fg_st_t st_d;

  // restart beats a coincident tick so the reference edge is never lost
  always_comb begin
    st_d = st_q;
    st_d.start = 1'b0;
    if (hold_i) begin
      st_d.pos = '0;
    end else if (restart_i) begin
      st_d.pos = '0; // R6
      st_d.start = 1'b1;
    end else if (tick_i) begin
      if (st_q.pos == FTS_FRAME_LAST) begin
        st_d.pos = '0; // R5
        st_d.start = 1'b1;
      end else begin
        st_d.pos = st_q.pos + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign frame_start_o = st_q.start;
  assign pos_o = st_q.pos;

  chk_frame_wrap: assert property ( // R5
    @(posedge clock_i) disable iff (sys_rst_i)
    (!hold_i && !restart_i && tick_i && st_q.pos == FTS_FRAME_LAST)
      |=> (st_q.pos == '0 && frame_start_o))
    else $error("frame counter did not wrap at end of frame");
endmodule

// ---- logic/fts_pkg.sv ----
/*
  shared constants and carrier types for the transmit framer timing
  reference selector: register map, field positions, reset values, mode
  codes and the AHB-Lite request and response bundles.
  assumes a single 50 MHz system clock and a 32-bit AHB-Lite bus.
*/
package fts_pkg;

  // register byte addresses
  localparam logic [31:0] FTS_ADDR_OP_MODE = 32'h0000_1100;
  localparam logic [31:0] FTS_ADDR_STATUS = 32'h0000_1104;

  // operating mode register fields and reset value
  localparam int FTS_BIT_LOOPBACK = 7;
  localparam int FTS_BIT_DS3_SEL = 6;
  localparam int FTS_BIT_LOS_EN = 5;
  localparam int FTS_BIT_SOFT_RST = 4;
  localparam int FTS_BIT_DIRECT_MAP = 3;
  localparam int FTS_BIT_FRAME_FMT = 2;
  localparam int FTS_TSEL_HI = 1;
  localparam int FTS_TSEL_LO = 0;
  localparam logic [7:0] FTS_OP_RESET = 8'h2B;

  // status register fields
  localparam int FTS_ST_RSVD = 2;
  localparam int FTS_ST_REF_LVL = 3;
  localparam int FTS_ST_FCNT_LO = 16;

  // timing source select codes
  localparam logic [1:0] FTS_TSEL_LOOP = 2'h0;
  localparam logic [1:0] FTS_TSEL_FREF = 2'h1;
  localparam logic [1:0] FTS_TSEL_RSVD = 2'h2;
  localparam logic [1:0] FTS_TSEL_ASYNC = 2'h3;

  // payload input interface mode numbers per timing mode
  localparam logic [2:0] FTS_SER_ASYNC = 3'h3;
  localparam logic [2:0] FTS_SER_FREF = 3'h2;
  localparam logic [2:0] FTS_SER_LOOP = 3'h1;
  localparam logic [2:0] FTS_NIB_ASYNC = 3'h6;
  localparam logic [2:0] FTS_NIB_FREF = 3'h5;
  localparam logic [2:0] FTS_NIB_LOOP = 3'h4;
  localparam logic [2:0] FTS_MODE_NONE = 3'h0;

  // last bit position of an outbound frame and counter width
  localparam int FTS_POS_W = 13;
  localparam logic [12:0] FTS_FRAME_LAST = 13'h1297;

  // bus codes
  localparam logic [1:0] FTS_HTRANS_NONSEQ = 2'h2;
  localparam logic FTS_HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } fts_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } fts_ahb_rsp_t;

endpackage

// ---- logic/fts_sync2.sv ----
/*
  two-flop synchroniser for a small vector of pin levels.
  assumes every bit is an independent level; no bit relation is kept.
*/
`timescale 1ns/1ps
module fts_sync2 #(
  parameter int W = 3
) (
  input wire logic clock_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [W-1:0] async_i, // pin levels
  output logic [W-1:0] sync_o // resynchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } fts_sync_st_t;

  fts_sync_st_t st_q;
  fts_sync_st_t st_d;

  // the first stage feeds only the second stage
  always_comb begin
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.sync;
endmodule

// ---- logic/fts_timing_ref.sv ----
/*
  timing reference selector of the transmit framer, with its AHB-Lite
  register slave: operating mode register and a status register.
  assumes the line clock, recovered clock and frame reference arrive as
  pins unrelated to clock_i; they are sampled, so each line clock edge is
  seen only while its period exceeds two system clock periods.
*/
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// [R1] select code 11 runs the framer in local asynchronous mode.
// [R2] select code 01 runs it locally with frames tied to the reference.
// [R3] select code 00 runs the framer in loop-timing mode.
// [R4] both local modes take bit timing from the transmit line clock pin.
// [R5] asynchronous and loop modes start frames free-running.
// [R6] reference mode starts a new frame on each reference rising edge.
// [R7] loop mode takes bit timing from the recovered receive clock.
// [R8] the board drives the line clock pin at 44.736MHz in local modes.
// [R9] the board ties the frame reference low outside reference mode.
// [R10] the board drives the reference at 9.398kHz in reference mode.
// [R11] the board derives the reference from the same line clock.
// [R12] in loop mode the board ensures a valid line or synthesised clock.
// [R13] early silicon needs a running line clock even in loop mode.
// [R14] each timing mode maps to one serial and one nibble payload mode.
// [R15] the line encoder uses B3ZS for DS3 and HDB3 for E3.
// [R16] the 8-bit mode register holds its fields at bits 7 down to 0.
// [R17] select code 10 is reserved and parks the framer.
module fts_timing_ref (
  input wire logic clock_i, // 50 MHz system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire fts_pkg::fts_ahb_req_t ahb_req_i, // AHB-Lite request
  output fts_pkg::fts_ahb_rsp_t ahb_rsp_o, // AHB-Lite response
  input wire logic tx_line_clock_in_i, // local transmit clock pin
  input wire logic rx_recovered_clock_i, // clock from receive line unit
  input wire logic tx_frame_sync_input_i, // frame reference pin
  output logic bit_tick_o, // pulse: one outbound bit time
  output logic frame_start_o, // pulse: new outbound frame
  output logic [fts_pkg::FTS_POS_W-1:0] frame_bit_pos_o, // bit in frame
  output logic [1:0] timing_source_select_o, // active select code
  output logic [2:0] payload_serial_mode_o, // serial payload mode
  output logic [2:0] payload_nibble_mode_o, // nibble payload mode
  output logic line_code_hdb3_o, // 1: HDB3, 0: B3ZS
  output logic local_loopback_o, // framer local loopback
  output logic ds3_not_e3_select_o, // 1: DS3, 0: E3
  output logic internal_signal_loss_enable_o, // internal_signal_loss_enable
  output logic framer_soft_reset_o, // framer reset bit
  output logic direct_cell_mapping_o, // direct mapping enable
  output logic frame_format_o // frame format bit
);
  import fts_pkg::*;

  // register address decode, shared by the read and write paths
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a[31:2] == r[31:2]);
  endfunction

  typedef struct packed {
    logic [7:0] op;
    logic wr_pend;
    logic [31:0] wr_addr;
    fts_ahb_rsp_t rsp;
    logic tick;
    logic ref_prev;
    logic clk_prev;
    logic restart;
    logic [15:0] frame_cnt;
    logic [2:0] ser_mode;
    logic [2:0] nib_mode;
    logic hdb3;
  } fts_st_t;

  fts_st_t st_q;
  fts_st_t st_d;

  logic [2:0] pins_sync;
  logic line_clk_s;
  logic rec_clk_s;
  logic ref_s;
  logic sel_clk;
  logic ref_rise;
  logic addr_phase;
  logic fg_start;
  logic [FTS_POS_W-1:0] fg_pos;
  logic [31:0] rd_val;
  logic [1:0] tsel;

  // pins are resynchronised before any logic looks at them
  fts_sync2 #(
    .W(3)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({tx_frame_sync_input_i, rx_recovered_clock_i,
              tx_line_clock_in_i}),
    .sync_o(pins_sync)
  );

  assign line_clk_s = pins_sync[0];
  assign rec_clk_s = pins_sync[1];
  assign ref_s = pins_sync[2];
  assign tsel = st_q.op[FTS_TSEL_HI:FTS_TSEL_LO];

  // clock source: line clock pin in both local modes, recovered in loop mode, none for the reserved code
  always_comb begin
    unique case (tsel)
      FTS_TSEL_ASYNC: sel_clk = line_clk_s; // R1 R4
      FTS_TSEL_FREF: sel_clk = line_clk_s; // R2 R4
      FTS_TSEL_LOOP: sel_clk = rec_clk_s; // R3 R7
      FTS_TSEL_RSVD: sel_clk = 1'b0; // R17
    endcase
  end

  // only reference mode takes frame restarts from the reference pin
  assign ref_rise = ref_s & ~st_q.ref_prev & (tsel == FTS_TSEL_FREF); // R6

  // an accepted address phase of a single transfer
  assign addr_phase = ahb_req_i.hsel & ahb_req_i.hready &
                      (ahb_req_i.htrans == FTS_HTRANS_NONSEQ);

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    // bus: write data land in the data phase, one cycle after the address
    if (st_q.wr_pend && hit(st_q.wr_addr, FTS_ADDR_OP_MODE)) begin
      st_d.op = ahb_req_i.hwdata[7:0]; // R16
    end
    // line code kept in its own flop so the pin is not an inverter output
    st_d.hdb3 = ~st_d.op[FTS_BIT_DS3_SEL]; // R15
    st_d.wr_pend = addr_phase & ahb_req_i.hwrite;
    st_d.wr_addr = ahb_req_i.haddr;
    st_d.rsp.hreadyout = 1'b1;
    st_d.rsp.hresp = FTS_HRESP_OKAY;
    // mode register read data come from the next value so a write just before is seen
    rd_val = '0;
    if (hit(ahb_req_i.haddr, FTS_ADDR_OP_MODE)) begin
      rd_val[7:0] = st_d.op;
    end else if (hit(ahb_req_i.haddr, FTS_ADDR_STATUS)) begin
      rd_val[1:0] = tsel;
      rd_val[FTS_ST_RSVD] = (tsel == FTS_TSEL_RSVD);
      rd_val[FTS_ST_REF_LVL] = ref_s;
      rd_val[FTS_ST_FCNT_LO +: 16] = st_q.frame_cnt;
    end
    if (addr_phase && !ahb_req_i.hwrite) begin
      st_d.rsp.hrdata = rd_val;
    end
    // timing: one tick per rising edge of the chosen clock
    st_d.clk_prev = sel_clk;
    st_d.ref_prev = ref_s;
    st_d.tick = sel_clk & ~st_q.clk_prev; // R4 R7
    st_d.restart = ref_rise; // R6
    if (fg_start) begin
      st_d.frame_cnt = st_q.frame_cnt + 16'h0001;
    end
    // payload interface mode implied by the timing mode
    unique case (st_d.op[FTS_TSEL_HI:FTS_TSEL_LO])
      FTS_TSEL_ASYNC: begin
        st_d.ser_mode = FTS_SER_ASYNC; // R14
        st_d.nib_mode = FTS_NIB_ASYNC;
      end
      FTS_TSEL_FREF: begin
        st_d.ser_mode = FTS_SER_FREF; // R14
        st_d.nib_mode = FTS_NIB_FREF;
      end
      FTS_TSEL_LOOP: begin
        st_d.ser_mode = FTS_SER_LOOP; // R14
        st_d.nib_mode = FTS_NIB_LOOP;
      end
      FTS_TSEL_RSVD: begin
        st_d.ser_mode = FTS_MODE_NONE; // R17
        st_d.nib_mode = FTS_MODE_NONE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.op <= FTS_OP_RESET;
      st_q.rsp.hreadyout <= 1'b1;
      st_q.ser_mode <= FTS_SER_ASYNC;
      st_q.nib_mode <= FTS_NIB_ASYNC;
      st_q.hdb3 <= ~FTS_OP_RESET[FTS_BIT_DS3_SEL];
    end else begin
      st_q <= st_d;
    end
  end

  // soft reset and the reserved code both park the frame counter
  fts_frame_gen u_frame (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .hold_i(st_q.op[FTS_BIT_SOFT_RST] | (tsel == FTS_TSEL_RSVD)), // R17
    .tick_i(st_q.tick),
    .restart_i(st_q.restart), // R6
    .frame_start_o(fg_start),
    .pos_o(fg_pos)
  );

  // outputs, all straight from flops
  assign ahb_rsp_o = st_q.rsp;
  assign bit_tick_o = st_q.tick;
  assign frame_start_o = fg_start;
  assign frame_bit_pos_o = fg_pos;
  assign timing_source_select_o = tsel;
  assign payload_serial_mode_o = st_q.ser_mode;
  assign payload_nibble_mode_o = st_q.nib_mode;
  assign line_code_hdb3_o = st_q.hdb3; // R15
  assign local_loopback_o = st_q.op[FTS_BIT_LOOPBACK]; // R16
  assign ds3_not_e3_select_o = st_q.op[FTS_BIT_DS3_SEL];
  assign internal_signal_loss_enable_o = st_q.op[FTS_BIT_LOS_EN];
  assign framer_soft_reset_o = st_q.op[FTS_BIT_SOFT_RST];
  assign direct_cell_mapping_o = st_q.op[FTS_BIT_DIRECT_MAP];
  assign frame_format_o = st_q.op[FTS_BIT_FRAME_FMT];

  chk_async_line_clk: assert property ( // R1
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_ASYNC && line_clk_s && !st_q.clk_prev && !st_q.tick)
      |=> bit_tick_o)
    else $error("asynchronous mode missed a line clock edge");

  chk_fref_restart: assert property ( // R2
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_FREF && ref_s && !st_q.ref_prev &&
     !st_q.op[FTS_BIT_SOFT_RST] && $stable(st_q.op))
      |=> ##1 (frame_start_o && frame_bit_pos_o == '0))
    else $error("reference edge did not start a frame two cycles on");

  chk_loop_rec_clk: assert property ( // R3
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_LOOP && rec_clk_s && !st_q.clk_prev)
      |=> bit_tick_o)
    else $error("loop mode missed a recovered clock edge");

  chk_local_ignores_rec: assert property ( // R4
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel[0] && !line_clk_s) |=> !bit_tick_o)
    else $error("local mode ticked without a line clock edge");

  chk_free_run: assert property ( // R5
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel != FTS_TSEL_FREF) |=> !st_q.restart)
    else $error("frame restart outside reference mode");

  chk_payload_map: assert property ( // R14
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_FREF && $stable(st_q.op))
      |-> (payload_serial_mode_o == FTS_SER_FREF &&
           payload_nibble_mode_o == FTS_NIB_FREF))
    else $error("payload mode does not follow timing mode");

  chk_line_code: assert property ( // R15
    @(posedge clock_i) disable iff (sys_rst_i)
    line_code_hdb3_o != ds3_not_e3_select_o)
    else $error("line code disagrees with DS3 or E3 select");

  chk_reg_write: assert property ( // R16
    @(posedge clock_i) disable iff (sys_rst_i)
    (addr_phase && ahb_req_i.hwrite &&
     hit(ahb_req_i.haddr, FTS_ADDR_OP_MODE))
      ##1 1'b1 |=> (st_q.op == $past(ahb_req_i.hwdata[7:0])))
    else $error("mode register did not take the written byte");

  chk_rsvd_parked: assert property ( // R17
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_RSVD) [*2] |=> (frame_bit_pos_o == '0 &&
                                       !bit_tick_o))
    else $error("reserved select code did not park the framer");

  chk_bus_okay: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ahb_rsp_o.hreadyout && ahb_rsp_o.hresp == FTS_HRESP_OKAY)
    else $error("slave stalled or answered with an error");

  chk_payload_async: assert property ( // R14
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_ASYNC)
      |-> (payload_serial_mode_o == FTS_SER_ASYNC &&
           payload_nibble_mode_o == FTS_NIB_ASYNC))
    else $error("payload mode does not follow asynchronous mode");

  chk_payload_loop: assert property ( // R14
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_LOOP)
      |-> (payload_serial_mode_o == FTS_SER_LOOP &&
           payload_nibble_mode_o == FTS_NIB_LOOP))
    else $error("payload mode does not follow loop mode");

  chk_payload_rsvd: assert property ( // R17
    @(posedge clock_i) disable iff (sys_rst_i)
    (tsel == FTS_TSEL_RSVD)
      |-> (payload_serial_mode_o == FTS_MODE_NONE &&
           payload_nibble_mode_o == FTS_MODE_NONE))
    else $error("reserved select code left a payload mode set");

  chk_soft_rst_hold: assert property ( // R16
    @(posedge clock_i) disable iff (sys_rst_i)
    framer_soft_reset_o |=> (frame_bit_pos_o == '0 && !frame_start_o))
    else $error("soft reset bit did not hold the frame counter");

  chk_tick_pulse: assert property ( // R4
    @(posedge clock_i) disable iff (sys_rst_i)
    bit_tick_o |=> !bit_tick_o)
    else $error("bit tick stood longer than one cycle");
endmodule

// ---- test/fts_board.sv ----
/*
  board model for the timing reference selector: line clock, recovered
  receive clock and frame reference pin.
  assumes clocks are slowed so the 50 MHz sampler can resolve them.
*/
`timescale 1ns/1ps
module fts_board #(
  parameter int LINE_HALF_NS = 50,
  parameter int REC_HALF_NS = 70,
  parameter int REF_DIV = 40
) (
  input wire logic ref_en_i, // drive the reference, else tie low
  output logic line_clk_o, // transmit line clock pin
  output logic rec_clk_o, // recovered receive clock
  output logic ref_o // frame reference pin
);
  int ref_cnt = 0;

  // line clock runs in every mode, loop mode included, as R13 asks
  initial begin
    line_clk_o = 1'b0;
    #3;
    forever #(LINE_HALF_NS) line_clk_o = ~line_clk_o;
  end

  // recovered clock stands for a valid received line, unrelated phase
  initial begin
    rec_clk_o = 1'b0;
    #13;
    forever #(REC_HALF_NS) rec_clk_o = ~rec_clk_o;
  end

  // reference counted off the line clock; ratio scaled down for run time
  initial ref_o = 1'b0;
  always @(posedge line_clk_o) begin
    if (!ref_en_i) begin
      ref_cnt <= 0;
      ref_o <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == REF_DIV - 1) ? 0 : ref_cnt + 1;
      ref_o <= (ref_cnt < REF_DIV / 2);
    end
  end
endmodule

// ---- test/fts_timing_ref_bench.sv ----
/*
  self-checking bench for the timing reference selector: register access
  over AHB-Lite, mode outputs, tick source, frame wrap and restart.
  assumes the board model in fts_board.sv drives the timing pins.
*/
`timescale 1ns/1ps
module fts_timing_ref_bench;
  import fts_pkg::*;
  localparam int LINE_HALF = 50;
  localparam int REC_HALF = 70;
  localparam int REF_DIV = 40;
  localparam int WIN = 1400;
  logic clock_i, sys_rst_i, ref_en;
  logic b_sel, b_write;
  logic [31:0] b_addr, b_wdata;
  logic [1:0] b_trans;
  logic [2:0] b_size;
  fts_ahb_req_t req;
  fts_ahb_rsp_t rsp;
  logic line_clk, rec_clk, fref, tick, fstart;
  logic [FTS_POS_W-1:0] pos;
  logic [1:0] tsel;
  logic [2:0] ser, nib;
  logic hdb3, lb, ds3, los, srst, dmap, ffmt;
  int failures, checks;

  // hready loops back from the only slave
  assign req = '{hsel: b_sel, haddr: b_addr, htrans: b_trans,
    hwrite: b_write, hsize: b_size, hwdata: b_wdata,
    hready: rsp.hreadyout};

  fts_board #(.LINE_HALF_NS(LINE_HALF), .REC_HALF_NS(REC_HALF),
    .REF_DIV(REF_DIV)) board (.ref_en_i(ref_en), .line_clk_o(line_clk),
    .rec_clk_o(rec_clk), .ref_o(fref));

  fts_timing_ref dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ahb_req_i(req), .ahb_rsp_o(rsp), .tx_line_clock_in_i(line_clk),
    .rx_recovered_clock_i(rec_clk), .tx_frame_sync_input_i(fref),
    .bit_tick_o(tick), .frame_start_o(fstart), .frame_bit_pos_o(pos),
    .timing_source_select_o(tsel), .payload_serial_mode_o(ser),
    .payload_nibble_mode_o(nib), .line_code_hdb3_o(hdb3),
    .local_loopback_o(lb), .ds3_not_e3_select_o(ds3),
    .internal_signal_loss_enable_o(los), .framer_soft_reset_o(srst),
    .direct_cell_mapping_o(dmap), .frame_format_o(ffmt));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi,
      input string what);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t %s: got %0d", $time, what, got);
    end
  endtask

  // wait for hready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (req.hready !== 1'b1 && n < 50);
    if (n >= 50) chk_rng(n, 0, 49, "bus wait");
  endtask

  // one single transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    b_sel <= 1'b1;
    b_addr <= a;
    b_write <= w;
    b_trans <= FTS_HTRANS_NONSEQ;
    wait_rdy();
    b_sel <= 1'b0;
    b_trans <= 2'h0;
    b_wdata <= wd;
    wait_rdy();
    rd = rsp.hrdata;
    chk(rsp.hresp, FTS_HRESP_OKAY, "response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdr(input logic [31:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask

  // count ticks and starts over a window, or together positions seen
  task automatic window(input int ncyc, output int t, output int s,
      output logic [FTS_POS_W-1:0] por);
    t = 0;
    s = 0;
    por = '0;
    repeat (ncyc) begin
      @(posedge clock_i);
      t += (tick === 1'b1);
      s += (fstart === 1'b1);
      por |= pos;
    end
  endtask

  // ticks from one frame start up to the next
  task automatic measure(output int t, output logic [FTS_POS_W-1:0] p0);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (fstart !== 1'b1 && n < 30000);
    p0 = pos;
    t = (tick === 1'b1);
    n = 0;
    forever begin
      @(posedge clock_i);
      n++;
      if (fstart === 1'b1 || n >= 30000) break;
      t += (tick === 1'b1);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch; normal run is near 55k cycles
  initial begin
    #1800000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic [31:0] d;
    int t, s, n;
    logic [FTS_POS_W-1:0] p;
    logic [2:0] es [4];
    logic [2:0] en [4];
    int et [4];
    failures = 0;
    checks = 0;
    sys_rst_i = 1'b1;
    ref_en = 1'b0;
    b_sel = 1'b0;
    b_write = 1'b0;
    b_addr = 32'h0;
    b_wdata = 32'h0;
    b_trans = 2'h0;
    b_size = 3'h2;
    es = '{FTS_SER_LOOP, FTS_SER_FREF, FTS_MODE_NONE, FTS_SER_ASYNC};
    en = '{FTS_NIB_LOOP, FTS_NIB_FREF, FTS_MODE_NONE, FTS_NIB_ASYNC};
    et = '{WIN * 10 / REC_HALF, WIN * 10 / LINE_HALF, 0,
      WIN * 10 / LINE_HALF};
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // reset state and an unmapped place
    rdr(FTS_ADDR_OP_MODE, d);
    chk(d, {24'h0, FTS_OP_RESET}, "op reset");
    chk(tsel, FTS_TSEL_ASYNC, "reset select");
    chk(ser, FTS_SER_ASYNC, "reset serial");
    chk(nib, FTS_NIB_ASYNC, "reset nibble");
    chk(hdb3, 1'b1, "reset line code");
    rdr(32'h0000_1200, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    // every select code: outputs and which clock gives ticks
    for (int i = 0; i < 4; i++) begin
      wr(FTS_ADDR_OP_MODE, {24'h0, FTS_OP_RESET[7:2], i[1:0]});
      rdr(FTS_ADDR_OP_MODE, d);
      chk(d, {24'h0, FTS_OP_RESET[7:2], i[1:0]}, "op readback");
      repeat (2) @(posedge clock_i);
      chk(tsel, i[1:0], "select out");
      chk(ser, es[i], "serial mode");
      chk(nib, en[i], "nibble mode");
      rdr(FTS_ADDR_STATUS, d);
      chk(d[3:0], {1'b0, i == 2, i[1:0]}, "status select");
      window(WIN, t, s, p);
      chk_rng(t, et[i] - 1, et[i] + 1, "tick rate");
      if (i == 2) chk_rng(s, 0, 0, "parked starts");
    end
    $display("test modes done");
    // all fields, upper bits dropped, soft reset parks the frame
    wr(FTS_ADDR_OP_MODE, 32'hFFFF_FFD4);
    rdr(FTS_ADDR_OP_MODE, d);
    chk(d, 32'h0000_00D4, "field readback");
    chk({lb, ds3, los, srst, dmap, ffmt, tsel}, 8'hD4, "field outs");
    chk(hdb3, 1'b0, "line code ds3");
    rdr(FTS_ADDR_STATUS, d);
    n = d[31:16];
    window(WIN, t, s, p);
    chk(p, '0, "parked position");
    chk_rng(s, 0, 0, "parked starts");
    rdr(FTS_ADDR_STATUS, d);
    chk(d, {n[15:0], 16'h0000}, "parked status");
    $display("test fields done");
    // free-running frame length in asynchronous mode
    wr(FTS_ADDR_OP_MODE, {24'h0, FTS_OP_RESET});
    rdr(FTS_ADDR_STATUS, d);
    n = d[31:16];
    measure(t, p);
    rdr(FTS_ADDR_STATUS, d);
    chk(d[31:16], n + 2, "frames counted");
    chk(p, '0, "start position");
    chk(t, {19'h0, FTS_FRAME_LAST} + 32'h1, "frame length");
    $display("test free run done");
    // reference mode: frames follow each reference rising edge
    ref_en <= 1'b1;
    wr(FTS_ADDR_OP_MODE, {24'h0, FTS_OP_RESET[7:2], FTS_TSEL_FREF});
    measure(t, p);
    measure(t, p);
    chk(t, REF_DIV, "reference interval");
    chk(p, '0, "restart position");
    @(posedge fref);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (fstart !== 1'b1 && n < 20);
    chk_rng(n, 3, 6, "restart latency");
    ref_en <= 1'b0;
    $display("test reference done");
    stop_test();
  end
endmodule
